// ---- hdl/bepr_err_track.v ----
// Write-error flags of one primary master: single and repeated.
// Assumes error and clear pulses are synchronous to SYS_CLK_IN.
`timescale 1ns/10ps
`default_nettype none
module bepr_err_track (
   // Clock and reset
   input wire clk_in,
   input wire rst_in,
   // Events
   input wire err_in,
   input wire clr_in,
   // Flags
   output wire single_out,
   output wire repeat_out
);
   reg single_r;
   reg repeat_r;
   // ==========================================================
   // Flags; a new error wins over a clear in the same cycle
   always @(posedge clk_in) begin
      if (rst_in) begin
         single_r <= 1'b0;
         repeat_r <= 1'b0;
      end else begin
         if (err_in) begin
            single_r <= 1'b1;
         end else if (clr_in) begin
            single_r <= 1'b0;
         end
         if (err_in && single_r) begin
            repeat_r <= 1'b1;
         end else if (clr_in) begin
            repeat_r <= 1'b0;
         end
      end
   end
   assign single_out = single_r;
   assign repeat_out = repeat_r;
endmodule
`default_nettype wire

// ---- hdl/bepr_param_word.v ----
// Constant words of the build configuration registers.
// Assumes parameters are fixed at elaboration; no state.
`timescale 1ns/10ps
`default_nettype none
`include "bepr_consts.vh"
module bepr_param_word #(
   parameter SPLIT = 1,
   parameter SYNC_CLK = 0,
   parameter NUM_MST = 3,
   parameter SBIG = 0,
   parameter SADDR64 = 0,
   parameter [1:0] SDATA_CODE = 2'h0,
   parameter MBIG = 0,
   parameter MADDR64 = 0,
   parameter [2:0] MDATA_CODE = 3'h2,
   parameter [7:0] WBUF_DEPTH = 8'h04,
   parameter [7:0] RBUF_DEPTH = 8'h04,
   parameter [3:0] PREF_DEPTH = 4'h1
) (
   // Words
   output wire [31:0] parm1_out,
   output wire [31:0] parm2_out
);
   localparam [3:0] NMST4 = NUM_MST[3:0];
   localparam SPLIT1 = (SPLIT != 0);
   localparam SYNC1 = (SYNC_CLK != 0);
   localparam SBIG1 = (SBIG != 0);
   localparam SADDR1 = (SADDR64 != 0);
   localparam MBIG1 = (MBIG != 0);
   localparam MADDR1 = (MADDR64 != 0);
   // ==========================================================
   // Unused bits 1:0 and 31:17 stay zero
   assign parm1_out = {15'h0000,
                       MDATA_CODE,
                       MADDR1[0],
                       MBIG1[0],
                       SDATA_CODE,
                       SADDR1[0],
                       SBIG1[0],
                       NMST4,
                       SYNC1[0],
                       SPLIT1[0],
                       2'h0};
   assign parm2_out = {12'h000, PREF_DEPTH, RBUF_DEPTH, WBUF_DEPTH};
endmodule
`default_nettype wire

// ---- hdl/bepr_regbank.v ----
// Local register bank of an AHB-to-AHB bridge slave port.
// Assumes the bridge slave decodes local accesses and issues one
// access per address phase, in bus order; datapath lies elsewhere.
`timescale 1ns/10ps
`default_nettype none
`include "bepr_consts.vh"
// How it works
// - Error on write while single flag set marks the repeated flag.
// - Repeated flag bit K belongs to master K, reset zero.
// - Repeated register reads zero in bit 0 and above master count.
// - Parameter one bit 2 shows split capability.
// - Parameter one bit 3 shows clock mode, 1 synchronous.
// - Parameter one bits 7:4 hold master count.
// - Parameter one bit 9 shows slave address width 64.
// - Parameter one bits 11:10 encode slave data width.
// - Parameter one bit 12 shows master big endian.
// - Parameter one bit 13 shows master address width 64.
// - Parameter one reserved bits read zero; rest read-only.
// - Parameter two holds write, read and prefetch buffer depths.
// - Parameter two bits 31:20 read zero.
// - Version register returns a fixed read-only identifier.
// - Type register returns a fixed read-only code.
// - Transfer size of local accesses is not checked.
// - Direction is not checked; writes to read-only registers accepted.
// - Local accesses execute in bus order with other transfers.
// - Local accesses complete inside, no secondary bus transfer.
// - Error response on a write sets that master's single flag.
// - Writing 1 to clear bit K clears both flags of master K.
// - Interrupt output is OR of all single flags.
module bepr_regbank #(
   parameter NUM_MST = 3,
   parameter SPLIT = 1,
   parameter SYNC_CLK = 0,
   parameter SBIG = 0,
   parameter SADDR64 = 0,
   parameter [1:0] SDATA_CODE = 2'h0,
   parameter MBIG = 0,
   parameter MADDR64 = 0,
   parameter [2:0] MDATA_CODE = 3'h2,
   parameter [7:0] WBUF_DEPTH = 8'h04,
   parameter [7:0] RBUF_DEPTH = 8'h04,
   parameter [3:0] PREF_DEPTH = 4'h1,
   parameter [31:0] VERSION_ID = `BEPR_VERSION_ID,
   parameter [31:0] TYPE_CODE = `BEPR_TYPE_CODE
) (
   // Clock and reset
   input wire SYS_CLK_IN,
   input wire RESET_IN,
   // Local register access from the bridge slave
   input wire REG_SEL_IN,
   input wire REG_WRITE_IN,
   input wire [9:0] REG_ADDR_IN,
   input wire [31:0] REG_WDATA_IN,
   output wire [31:0] REG_RDATA_OUT,
   output wire REG_DONE_OUT,
   // Write error reports from the bridge master
   input wire WERR_VALID_IN,
   input wire [3:0] WERR_MASTER_IN,
   // Interrupt
   output wire WERR_IRQ_OUT
);
   // ==========================================================
   // Address phase capture
   // Data phase follows the address phase; write data sampled then.
   reg aph_valid_r;
   reg aph_write_r;
   reg [9:0] aph_addr_r;
   reg [31:0] rdata_r;
   reg done_r;
   reg irq_r;
   wire [NUM_MST:1] single_w;
   wire [NUM_MST:1] repeat_w;
   wire [31:0] parm1_w;
   wire [31:0] parm2_w;
   wire [31:0] single_word_w;
   wire [31:0] repeat_word_w;
   wire clr_wr_w;
   reg [31:0] rd_nxt;

   always @(posedge SYS_CLK_IN) begin
      if (RESET_IN) begin
         aph_valid_r <= 1'b0;
         aph_write_r <= 1'b0;
         aph_addr_r <= 10'h000;
      end else begin
         // Size is ignored; one access per address phase, in order
         aph_valid_r <= REG_SEL_IN;
         aph_write_r <= REG_WRITE_IN;
         aph_addr_r <= REG_ADDR_IN;
      end
   end

   // Only the clear register reacts to a write; others ignore it
   assign clr_wr_w = aph_valid_r && aph_write_r && (aph_addr_r == `BEPR_OFS_CLEAR);

   // ==========================================================
   // Per-master error flags
   genvar k;
   generate
      for (k = 1; k <= NUM_MST; k = k + 1) begin : g_mst
         bepr_err_track u_trk (
            .clk_in(SYS_CLK_IN),
            .rst_in(RESET_IN),
            .err_in(WERR_VALID_IN && (WERR_MASTER_IN == k)),
            .clr_in(clr_wr_w && REG_WDATA_IN[k]),
            .single_out(single_w[k]),
            .repeat_out(repeat_w[k])
         );
      end
   endgenerate

   // Bit 0 and bits above the master count read zero
   assign single_word_w = {{(31 - NUM_MST){1'b0}}, single_w, 1'b0};
   assign repeat_word_w = {{(31 - NUM_MST){1'b0}}, repeat_w, 1'b0};

   // ==========================================================
   // Build configuration words
   bepr_param_word #(
      .SPLIT(SPLIT),
      .SYNC_CLK(SYNC_CLK),
      .NUM_MST(NUM_MST),
      .SBIG(SBIG),
      .SADDR64(SADDR64),
      .SDATA_CODE(SDATA_CODE),
      .MBIG(MBIG),
      .MADDR64(MADDR64),
      .MDATA_CODE(MDATA_CODE),
      .WBUF_DEPTH(WBUF_DEPTH),
      .RBUF_DEPTH(RBUF_DEPTH),
      .PREF_DEPTH(PREF_DEPTH)
   ) u_parm (
      .parm1_out(parm1_w),
      .parm2_out(parm2_w)
   );

   // ==========================================================
   // Read mux; unmapped offsets and the clear register read zero
   always @* begin
      rd_nxt = 32'h00000000;
      case (REG_ADDR_IN)
         `BEPR_OFS_SINGLE: rd_nxt = single_word_w;
         `BEPR_OFS_REPEAT: rd_nxt = repeat_word_w;
         `BEPR_OFS_PARM1: rd_nxt = parm1_w;
         `BEPR_OFS_PARM2: rd_nxt = parm2_w;
         `BEPR_OFS_VERSION: rd_nxt = VERSION_ID;
         `BEPR_OFS_TYPE: rd_nxt = TYPE_CODE;
         default: rd_nxt = 32'h00000000;
      endcase
   end

   // Registered outputs; access ends here, nothing goes downstream
   always @(posedge SYS_CLK_IN) begin
      if (RESET_IN) begin
         rdata_r <= `BEPR_RST_FLAGS;
         done_r <= 1'b0;
         irq_r <= 1'b0;
      end else begin
         rdata_r <= (REG_SEL_IN && !REG_WRITE_IN) ? rd_nxt : 32'h00000000;
         done_r <= REG_SEL_IN;
         irq_r <= |single_w;
      end
   end

   assign REG_RDATA_OUT = rdata_r;
   assign REG_DONE_OUT = done_r;
   assign WERR_IRQ_OUT = irq_r;
endmodule
`default_nettype wire

// ---- inc/bepr_consts.vh ----
// Offsets, field positions and fixed codes of the bridge local register bank.
// Included by the bank modules; holds definitions only.
`ifndef BEPR_CONSTS_VH
`define BEPR_CONSTS_VH
// ==========================================================
// Register offsets (byte addresses)
`define BEPR_OFS_CLEAR 10'h000
`define BEPR_OFS_SINGLE 10'h004
`define BEPR_OFS_REPEAT 10'h008
`define BEPR_OFS_PARM1 10'h3F0
`define BEPR_OFS_PARM2 10'h3F4
`define BEPR_OFS_VERSION 10'h3F8
`define BEPR_OFS_TYPE 10'h3FC
// ==========================================================
// Parameter register one field positions
`define BEPR_P1_SPLIT 2
`define BEPR_P1_CLKMODE 3
`define BEPR_P1_NMST_LO 4
`define BEPR_P1_SBO 8
`define BEPR_P1_SADDR 9
`define BEPR_P1_SDATA_LO 10
`define BEPR_P1_MBO 12
`define BEPR_P1_MADDR 13
`define BEPR_P1_MDATA_LO 14
// ==========================================================
// Parameter register two field positions
`define BEPR_P2_WBUF_LO 0
`define BEPR_P2_RBUF_LO 8
`define BEPR_P2_PREF_LO 16
// ==========================================================
// Reset values and fixed codes (identity values are arbitrary)
`define BEPR_RST_FLAGS 32'h00000000
`define BEPR_VERSION_ID 32'h31303061
`define BEPR_TYPE_CODE 32'h58590001
`endif

// ---- sim/bepr_master_model.sv ----
// Primary master model: one 32-bit local access at a time.
// Assumes accesses start just after a rising edge.
`timescale 1ns/10ps
`default_nettype none
module bepr_master_model (
   // Answer
   input wire logic clk_in,
   input wire logic done_in,
   input wire logic [31:0] rdata_in,
   // Request
   output logic sel_out,
   output logic wr_out,
   output logic [9:0] addr_out,
   output logic [31:0] wdata_out
);
   initial begin
      sel_out = 1'b0;
      wr_out = 1'b0;
      addr_out = 10'h155;
      wdata_out = 32'h0;
   end
   // =========================================
   // Whole words only, never a narrow beat
   task automatic acc(input logic w, input logic [9:0] a, input logic [31:0] d,
         output logic [31:0] q, output logic ok);
      @(posedge clk_in);
      #1;
      sel_out = 1'b1;
      wr_out = w;
      addr_out = a;
      @(posedge clk_in);
      #1;
      sel_out = 1'b0;
      // Released lines flip so stale values cannot pass
      addr_out = ~a;
      wdata_out = d;
      q = rdata_in;
      ok = done_in;
      @(posedge clk_in);
      #1;
      wdata_out = ~d;
   endtask
endmodule
`default_nettype wire

// ---- sim/bepr_regbank_chk.sv ----
// Port assertions for the local register bank.
// Assumes one clock domain.
`timescale 1ns/10ps
`default_nettype none
`include "bepr_consts.vh"
module bepr_regbank_chk #(
   parameter NUM_MST = 3
) (
   input wire logic SYS_CLK_IN,
   input wire logic RESET_IN,
   input wire logic REG_SEL_IN,
   input wire logic REG_WRITE_IN,
   input wire logic [9:0] REG_ADDR_IN,
   input wire logic [31:0] REG_RDATA_OUT,
   input wire logic REG_DONE_OUT,
   input wire logic WERR_VALID_IN,
   input wire logic [3:0] WERR_MASTER_IN,
   input wire logic WERR_IRQ_OUT
);
   default clocking cb @(posedge SYS_CLK_IN);
   endclocking
   default disable iff (RESET_IN);
   wire rs = REG_SEL_IN && !REG_WRITE_IN;
   wire [31:0] q = REG_RDATA_OUT;
   a_done_one_late: assert property (REG_SEL_IN |=> REG_DONE_OUT)
      else $error("done missing");
   a_idle_reads_zero: assert property (!rs |=> q == 32'h0)
      else $error("stray read data");
   a_parm1_fields: assert property (rs && REG_ADDR_IN == `BEPR_OFS_PARM1 |=>
      q[7:4] == NUM_MST && q[1:0] == 2'h0 && q[31:17] == 15'h0)
      else $error("parameter one wrong");
   a_parm2_upper: assert property (rs && REG_ADDR_IN == `BEPR_OFS_PARM2 |=>
      q[31:20] == 12'h0)
      else $error("parameter two wrong");
   a_version_fixed: assert property (rs && REG_ADDR_IN == `BEPR_OFS_VERSION |=>
      q == `BEPR_VERSION_ID)
      else $error("version wrong");
   a_type_fixed: assert property (rs && REG_ADDR_IN == `BEPR_OFS_TYPE |=>
      q == `BEPR_TYPE_CODE)
      else $error("type wrong");
   a_repeat_reserved: assert property (rs && REG_ADDR_IN == `BEPR_OFS_REPEAT |=>
      q[0] == 1'b0 && (q >> (NUM_MST + 1)) == 32'h0)
      else $error("repeat reserved set");
   a_irq_from_error: assert property (WERR_VALID_IN &&
      WERR_MASTER_IN inside {[1:NUM_MST]} |-> ##2 WERR_IRQ_OUT)
      else $error("irq missing");
   cover property (rs);
   cover property (REG_SEL_IN && REG_WRITE_IN);
   cover property ($rose(WERR_IRQ_OUT));
endmodule
`default_nettype wire

// ---- sim/bepr_regbank_test.sv ----
// Bench for the local register bank, default build.
// Assumes the master model issues all register accesses.
`timescale 1ns/10ps
`default_nettype none
`include "bepr_consts.vh"
module bepr_regbank_test;
   logic clk, rst, wv, ok;
   logic [3:0] wm;
   logic [31:0] q;
   wire sel, wr, done, irq;
   wire [9:0] ad;
   wire [31:0] wd, rd;
   int err_count = 0;
   int comparisons = 0;
   logic [41:0] rows [8] = '{{10'h3F0, 32'h00008034}, {10'h3F4, 32'h00010404},
      {10'h3F8, `BEPR_VERSION_ID}, {10'h3FC, `BEPR_TYPE_CODE}, {10'h008, 32'h0},
      {10'h004, 32'h0}, {10'h000, 32'h0}, {10'h100, 32'h0}};
   bepr_regbank dut (.SYS_CLK_IN(clk), .RESET_IN(rst), .REG_SEL_IN(sel),
      .REG_WRITE_IN(wr), .REG_ADDR_IN(ad), .REG_WDATA_IN(wd), .REG_RDATA_OUT(rd),
      .REG_DONE_OUT(done), .WERR_VALID_IN(wv), .WERR_MASTER_IN(wm), .WERR_IRQ_OUT(irq));
   bepr_master_model m (.clk_in(clk), .done_in(done), .rdata_in(rd), .sel_out(sel),
      .wr_out(wr), .addr_out(ad), .wdata_out(wd));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rdc(input logic [9:0] a, input logic [31:0] exp);
      m.acc(1'b0, a, 32'h0, q, ok);
      check({31'h0, ok}, 32'h1);
      check(q, exp);
   endtask
   task automatic wrc(input logic [9:0] a, input logic [31:0] d);
      m.acc(1'b1, a, d, q, ok);
      check({31'h0, ok}, 32'h1);
   endtask
   task automatic err(input logic [3:0] k);
      @(posedge clk);
      #1;
      wv = 1'b1;
      wm = k;
      @(posedge clk);
      #1;
      wv = 1'b0;
      wm = ~k;
   endtask
   task automatic give_verdict;
      $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial begin
      repeat (3000) @(posedge clk);
      err_count++;
      give_verdict;
   end
   initial begin
      wv = 1'b0;
      wm = 4'h0;
      rst = 1'b1;
      repeat (12) @(posedge clk);
      #1;
      check({29'h0, done, irq, rd != 32'h0}, 32'h0);
      rst = 1'b0;
      $display("reset test done");
      for (int i = 0; i < 8; i++) rdc(rows[i][41:32], rows[i][31:0]);
      $display("table test done");
      err(4'h2);
      rdc(`BEPR_OFS_SINGLE, 32'h4);
      check({31'h0, irq}, 32'h1);
      rdc(`BEPR_OFS_REPEAT, 32'h0);
      for (int k = 1; k <= 3; k++) err(k[3:0]);
      err(4'h0);
      err(4'h5);
      rdc(`BEPR_OFS_SINGLE, 32'hE);
      rdc(`BEPR_OFS_REPEAT, 32'h4);
      err(4'h1);
      err(4'h3);
      rdc(`BEPR_OFS_REPEAT, 32'hE);
      $display("error test done");
      wrc(`BEPR_OFS_CLEAR, 32'h0);
      rdc(`BEPR_OFS_SINGLE, 32'hE);
      // Reserved bits set too: only master 2 may clear
      wrc(`BEPR_OFS_CLEAR, 32'hFFFFFFF5);
      rdc(`BEPR_OFS_SINGLE, 32'hA);
      rdc(`BEPR_OFS_REPEAT, 32'hA);
      wrc(`BEPR_OFS_PARM1, 32'hFFFFFFFF);
      rdc(`BEPR_OFS_PARM1, 32'h00008034);
      wrc(`BEPR_OFS_CLEAR, 32'hA);
      rdc(`BEPR_OFS_SINGLE, 32'h0);
      check({31'h0, irq}, 32'h0);
      $display("clear test done");
      // Error lands on the same edge as its clear: the set must win
      fork
         wrc(`BEPR_OFS_CLEAR, 32'h2);
         begin
            @(posedge clk);
            err(4'h1);
         end
      join
      rdc(`BEPR_OFS_SINGLE, 32'h2);
      rdc(`BEPR_OFS_REPEAT, 32'h0);
      check({31'h0, irq}, 32'h1);
      err(4'h1);
      rdc(`BEPR_OFS_REPEAT, 32'h2);
      $display("set wins test done");
      // Mid-run reset drops every flag
      @(posedge clk);
      #1;
      rst = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      rst = 1'b0;
      check({30'h0, done, irq}, 32'h0);
      rdc(`BEPR_OFS_SINGLE, 32'h0);
      rdc(`BEPR_OFS_REPEAT, 32'h0);
      $display("mid-run reset test done");
      give_verdict;
   end
endmodule
bind bepr_regbank bepr_regbank_chk #(.NUM_MST(NUM_MST)) chk (.SYS_CLK_IN(SYS_CLK_IN),
   .RESET_IN(RESET_IN), .REG_SEL_IN(REG_SEL_IN), .REG_WRITE_IN(REG_WRITE_IN),
   .REG_ADDR_IN(REG_ADDR_IN), .REG_RDATA_OUT(REG_RDATA_OUT), .REG_DONE_OUT(REG_DONE_OUT),
   .WERR_VALID_IN(WERR_VALID_IN), .WERR_MASTER_IN(WERR_MASTER_IN),
   .WERR_IRQ_OUT(WERR_IRQ_OUT));
`default_nettype wire
